//--- include/speh_pkg.sv
package speh_pkg;
   // Register byte offsets
   localparam logic [7:0] SPEH_OFF_STATUS  = 8'h00;  // Sticky error status, write one to clear
   localparam logic [7:0] SPEH_OFF_ENABLE  = 8'h04;  // Status enables and global enable
   localparam logic [7:0] SPEH_OFF_CONTROL = 8'h08;  // Start control, switching mode
   localparam logic [7:0] SPEH_OFF_PORTST  = 8'h0C;  // Running, halt, failing device
   localparam logic [7:0] SPEH_OFF_LINKERR = 8'h10;  // Link error register, write one to clear
   // Status bit positions
   localparam int SPEH_ST_OFS  = 0;   // Overflow
   localparam int SPEH_ST_INFS = 1;   // Non-fatal interface
   localparam int SPEH_ST_IFS  = 2;   // Fatal interface
   localparam int SPEH_ST_HBFS = 3;   // Host bus fatal
   localparam int SPEH_ST_HBDS = 4;   // Host data error
   localparam int SPEH_ST_TFES = 5;   // Taskfile error
   localparam int SPEH_ST_W    = 6;   // Status width
   // Control and port status bits
   localparam int SPEH_CT_START = 0;  // Port start control
   localparam int SPEH_CT_FBS   = 1;  // Switching enable
   localparam int SPEH_EN_GLOB  = 31; // Global interrupt enable position
   localparam int SPEH_PS_CR    = 0;  // Command running indicator
   localparam int SPEH_PS_HALT  = 1;  // Fatal halt
   localparam int SPEH_PS_SDE   = 2;  // Single device error flag
   localparam int SPEH_PS_DEV   = 4;  // Failing device field base
   // Link error bits
   localparam int SPEH_LE_PROTO = 0;  // Protocol error bit
   localparam int SPEH_LE_CRC   = 1;  // CRC error
   localparam int SPEH_LE_RERR  = 2;  // R_ERR received
   localparam int SPEH_LE_W     = 3;
   localparam logic [31:0] SPEH_RST_WORD = 32'h0000_0000; // Reset value of all registers

   // Link-side events: one-cycle error pulses plus level qualifiers (slot, idle, device, bytes)
   typedef struct packed {
      logic       rd_overflow;    // Read data beyond table
      logic       wr_dma_activate;// Extra DMA Activate with table exhausted
      logic       rd_underflow;   // Read ended short of table
      logic       ncq_cmd;        // Current command is queued
      logic       pio_data_odd;   // Intermediate PIO data not whole Dwords
      logic       pio_data_len;   // PIO data length mismatch
      logic       esc_d2h;        // Device escaped a received FIS
      logic       esc_h2d_data;   // Escape on sent Data FIS
      logic       esc_h2d_ctl;    // Escape on sent non-Data FIS
      logic       rerr_h2d_data;  // R_ERR on sent Data FIS
      logic       rerr_h2d_ctl;   // R_ERR on sent non-Data FIS
      logic       crc_data;       // CRC error on received Data FIS
      logic       crc_ctl;        // CRC error on received non-Data FIS
      logic       d2h_fis;        // Valid D2H FIS received
      logic       d2h_dma_setup;  // That FIS is DMA Setup
      logic       d2h_reg_err;    // That FIS is Register FIS with error bit
      logic       slot_active;    // Device has an active command slot
      logic       host_bus_fatal; // Host bus fatal error
      logic       host_data_err;  // Host data error
      logic       taskfile_err;   // Taskfile error
      logic       ctl_done;       // Retried non-Data FIS accepted
      logic       link_idle;      // Device is quiescent
      logic [3:0] dev;            // Device of the event
      logic [15:0] last_fis_bytes;// Bytes of last received FIS
   } speh_evt_t;

   // Actions toward the link layer
   typedef struct packed {
      logic        send_escape;   // Abort current FIS
      logic        send_hold;     // Hold device, no data
      logic        send_rerr;     // Answer R_ERR
      logic        retry_ctl;     // Retransmit failed non-Data FIS
      logic        post_fis;      // Post received FIS
      logic        ack_dma_setup; // Acknowledge DMA Setup
      logic        issue_ok;      // New commands may issue
      logic        bc_we;         // Write descriptor byte count
      logic [15:0] bc_value;      // Byte count value
   } speh_act_t;
endpackage

//--- src/speh_port_error.sv
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
// Operation
// - Read overflow sets status, interrupt, continues
// - DMA write overflow holds, flags on Activate
// - Switching overflow records device, single error
// - Read underflow loads descriptor byte count
// - Queued underflow and tag unchecked
// - Odd intermediate PIO data is fatal
// - PIO length mismatch: R_ERR, fatal
// - Device escape on received FIS fatal
// - Escape on sent Data FIS fatal
// - Escape on control FIS depends on switching
// - R_ERR on Data FIS fatal halt unless switching
// - Switching R_ERR Data: link bits, continue
// - R_ERR control FIS non-fatal, retransmit
// - CRC error: Data fatal, control non-fatal
// - Stray DMA Setup is fatal
// - Other stray D2H FIS silently dropped
// - Abort sends escape, idles when quiet
// - Abort reports errors without waiting
// - Fatal status halts, clears running
// - Restart by start clear then set
// - Non-fatal errors keep port operating
// - Retry control FIS until success or stop
module speh_port_error
   import speh_pkg::*;
#(
   parameter int DEV_W = 4  // Failing device field width
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire speh_evt_t   evt,
   output speh_act_t        act,
   output logic             irq
);
   // Abort sequence states
   typedef enum logic [1:0] {SPEH_IDLE, SPEH_ESC, SPEH_WAITQ} speh_ab_t;

   logic [SPEH_ST_W-1:0] sts_ff, nxt_sts;     // Sticky status
   logic [SPEH_ST_W-1:0] en_ff, nxt_en;       // Status enables
   logic                 glob_ff, nxt_glob;   // Global enable
   logic                 start_ff, nxt_start; // Start control
   logic                 fbs_ff, nxt_fbs;     // Switching enable
   logic                 halt_ff, nxt_halt;   // Fatal halt
   logic                 cr_ff, nxt_cr;       // Command running
   logic                 sde_ff, nxt_sde;     // Single device error
   logic [DEV_W-1:0]     dev_ff, nxt_dev;     // Failing device
   logic [SPEH_LE_W-1:0] le_ff, nxt_le;       // Link errors
   logic                 retry_ff, nxt_retry; // Control FIS retry pending
   logic                 rtw_ff, nxt_rtw;     // Resend out, outcome awaited
   speh_ab_t             ab_ff, nxt_ab;       // Abort state
   logic [31:0]          rd_ff, nxt_rd;       // Read data
   logic                 rdy_ff, nxt_rdy;     // Ready
   logic                 err_ff, nxt_err;     // Slave error
   speh_act_t            act_ff, nxt_act;     // Link actions
   logic                 irq_ff, nxt_irq;     // Interrupt

   // Known register offset check
   function automatic logic speh_mapped(input logic [7:0] a);
      speh_mapped = (a == SPEH_OFF_STATUS) || (a == SPEH_OFF_ENABLE) || (a == SPEH_OFF_CONTROL)
                 || (a == SPEH_OFF_PORTST) || (a == SPEH_OFF_LINKERR);
   endfunction

   // Writes land at the edge that ends the access, reads are fetched one earlier
   logic wr_acc;   // Write in access phase, with ready
   logic rd_acc;   // Read in access phase, before ready
   assign wr_acc = psel && penable && pwrite && rdy_ff;
   assign rd_acc = psel && penable && !pwrite && !rdy_ff;

   // Error classification, control and bus
   always_comb
   begin
      logic [SPEH_ST_W-1:0] set_s;  // Status to set
      logic [SPEH_LE_W-1:0] set_l;  // Link bits to set
      logic                 rec;    // Record failing device
      logic                 stray;  // D2H FIS with no slot
      logic                 abort;  // Unrecoverable, abort link
      set_s = '0;
      set_l = '0;
      rec   = 1'b0;
      stray = evt.d2h_fis && !evt.slot_active;
      abort = 1'b0;
      nxt_act = '0;
      // Overflow on reads, and DMA write overflow on extra Activate
      if (evt.rd_overflow || evt.wr_dma_activate)
      begin
         set_s[SPEH_ST_OFS] = 1'b1;
         rec = fbs_ff;
      end
      nxt_act.send_hold = evt.wr_dma_activate;
      abort = evt.wr_dma_activate;
      // Underflow only for non-queued reads
      nxt_act.bc_we    = evt.rd_underflow && !evt.ncq_cmd;
      nxt_act.bc_value = evt.last_fis_bytes;
      // PIO size errors
      if (evt.pio_data_odd || evt.pio_data_len)
      begin
         set_l[SPEH_LE_PROTO] = 1'b1;
         set_s[SPEH_ST_IFS]   = 1'b1;
      end
      nxt_act.send_rerr = evt.pio_data_len || evt.crc_data || evt.crc_ctl;
      // SYNC Escape by device
      if (evt.esc_d2h || evt.esc_h2d_data)
         set_s[SPEH_ST_IFS] = 1'b1;
      if (evt.esc_h2d_ctl)
      begin
         if (fbs_ff)
         begin
            set_s[SPEH_ST_INFS] = 1'b1;
            rec = 1'b1;
         end
         else
            set_s[SPEH_ST_IFS] = 1'b1;
      end
      // R_ERR from device
      if (evt.rerr_h2d_data)
      begin
         set_l[SPEH_LE_RERR] = 1'b1;
         if (!fbs_ff)
            set_s[SPEH_ST_IFS] = 1'b1;
      end
      if (evt.rerr_h2d_ctl)
      begin
         set_l[SPEH_LE_RERR] = 1'b1;
         set_s[SPEH_ST_INFS] = 1'b1;
      end
      // CRC on received FIS
      if (evt.crc_data || evt.crc_ctl)
         set_l[SPEH_LE_CRC] = 1'b1;
      if (evt.crc_data)
         set_s[SPEH_ST_IFS] = 1'b1;
      if (evt.crc_ctl)
         set_s[SPEH_ST_INFS] = 1'b1;
      // Stray DMA Setup is fatal, others dropped
      if (stray && evt.d2h_dma_setup)
         set_s[SPEH_ST_IFS] = 1'b1;
      nxt_act.post_fis = evt.d2h_fis && evt.slot_active;
      // Register FIS with error under switching declares device error
      if (evt.d2h_fis && evt.slot_active && evt.d2h_reg_err && fbs_ff)
         rec = 1'b1;
      // Host side faults
      set_s[SPEH_ST_HBFS] = evt.host_bus_fatal;
      set_s[SPEH_ST_HBDS] = evt.host_data_err;
      set_s[SPEH_ST_TFES] = evt.taskfile_err;
      abort = abort || evt.esc_h2d_data || evt.pio_data_odd || evt.host_bus_fatal
              || evt.host_data_err;
      // Status registers: set wins over clear
      nxt_sts = sts_ff;
      nxt_le  = le_ff;
      if (wr_acc && paddr == SPEH_OFF_STATUS)
         nxt_sts = sts_ff & ~pwdata[SPEH_ST_W-1:0];
      if (wr_acc && paddr == SPEH_OFF_LINKERR)
         nxt_le = le_ff & ~pwdata[SPEH_LE_W-1:0];
      nxt_sts = nxt_sts | set_s;
      nxt_le  = nxt_le | set_l;
      nxt_sde = sde_ff;
      nxt_dev = dev_ff;
      if (wr_acc && paddr == SPEH_OFF_PORTST && pwdata[SPEH_PS_SDE])
         nxt_sde = 1'b0;
      if (rec)
      begin
         nxt_sde = 1'b1;
         nxt_dev = evt.dev[DEV_W-1:0];
      end
      // Enables and control
      nxt_en    = en_ff;
      nxt_glob  = glob_ff;
      nxt_start = start_ff;
      nxt_fbs   = fbs_ff;
      if (wr_acc && paddr == SPEH_OFF_ENABLE)
      begin
         nxt_en   = pwdata[SPEH_ST_W-1:0];
         nxt_glob = pwdata[SPEH_EN_GLOB];
      end
      if (wr_acc && paddr == SPEH_OFF_CONTROL)
      begin
         nxt_start = pwdata[SPEH_CT_START];
         nxt_fbs   = pwdata[SPEH_CT_FBS];
      end
      // Fatal halt; leaves only when start goes from 0 to 1
      nxt_halt = halt_ff;
      if (|(set_s & ((6'h01 << SPEH_ST_IFS) | (6'h01 << SPEH_ST_HBFS)
                   | (6'h01 << SPEH_ST_HBDS) | (6'h01 << SPEH_ST_TFES))))
         nxt_halt = 1'b1;
      else if (!start_ff && nxt_start)
         nxt_halt = 1'b0;
      nxt_cr = nxt_start && !nxt_halt;
      // Control FIS retry until done or stopped; other FISes still served
      nxt_retry = retry_ff;
      if (evt.rerr_h2d_ctl || (evt.esc_h2d_ctl && fbs_ff))
         nxt_retry = 1'b1;
      else if (evt.ctl_done || !start_ff)
         nxt_retry = 1'b0;
      // One resend at a time; its outcome is awaited before the next
      nxt_rtw = rtw_ff;
      if (act_ff.retry_ctl)
         nxt_rtw = 1'b1;
      if (evt.rerr_h2d_ctl || evt.ctl_done || !start_ff)
         nxt_rtw = 1'b0;
      nxt_act.retry_ctl = retry_ff && !rtw_ff && !act_ff.retry_ctl && start_ff && !evt.d2h_fis;
      nxt_act.issue_ok      = nxt_cr;
      nxt_act.ack_dma_setup = nxt_cr && evt.d2h_fis && evt.d2h_dma_setup && evt.slot_active;
      // Abort: one escape cycle, then wait until device quiet
      nxt_ab = ab_ff;
      case (ab_ff)
         SPEH_IDLE:  if (abort) nxt_ab = SPEH_ESC;
         SPEH_ESC:   nxt_ab = SPEH_WAITQ;
         SPEH_WAITQ: if (evt.link_idle) nxt_ab = SPEH_IDLE;
         default:    nxt_ab = SPEH_IDLE;
      endcase
      nxt_act.send_escape = (nxt_ab == SPEH_ESC);
      nxt_irq = |(nxt_sts & nxt_en) && nxt_glob;
      // APB answer one cycle into access
      nxt_rdy = psel && penable && !rdy_ff;
      nxt_err = psel && penable && !rdy_ff && !speh_mapped(paddr);
      nxt_rd  = SPEH_RST_WORD;
      if (rd_acc)
      begin
         case (paddr)
            SPEH_OFF_STATUS:  nxt_rd[SPEH_ST_W-1:0] = sts_ff;
            SPEH_OFF_ENABLE:
            begin
               nxt_rd[SPEH_ST_W-1:0]  = en_ff;
               nxt_rd[SPEH_EN_GLOB]   = glob_ff;
            end
            SPEH_OFF_CONTROL:
            begin
               nxt_rd[SPEH_CT_START] = start_ff;
               nxt_rd[SPEH_CT_FBS]   = fbs_ff;
            end
            SPEH_OFF_PORTST:
            begin
               nxt_rd[SPEH_PS_CR]   = cr_ff;
               nxt_rd[SPEH_PS_HALT] = halt_ff;
               nxt_rd[SPEH_PS_SDE]  = sde_ff;
               nxt_rd[SPEH_PS_DEV +: DEV_W] = dev_ff;
            end
            SPEH_OFF_LINKERR: nxt_rd[SPEH_LE_W-1:0] = le_ff;
            default:          nxt_rd = SPEH_RST_WORD;
         endcase
      end
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sts_ff   <= '0;
         en_ff    <= '0;
         glob_ff  <= 1'b0;
         start_ff <= 1'b0;
         fbs_ff   <= 1'b0;
         halt_ff  <= 1'b0;
         cr_ff    <= 1'b0;
         sde_ff   <= 1'b0;
         dev_ff   <= '0;
         le_ff    <= '0;
         retry_ff <= 1'b0;
         rtw_ff   <= 1'b0;
         ab_ff    <= SPEH_IDLE;
         rd_ff    <= SPEH_RST_WORD;
         rdy_ff   <= 1'b0;
         err_ff   <= 1'b0;
         act_ff   <= '0;
         irq_ff   <= 1'b0;
      end
      else
      begin
         sts_ff   <= nxt_sts;
         en_ff    <= nxt_en;
         glob_ff  <= nxt_glob;
         start_ff <= nxt_start;
         fbs_ff   <= nxt_fbs;
         halt_ff  <= nxt_halt;
         cr_ff    <= nxt_cr;
         sde_ff   <= nxt_sde;
         dev_ff   <= nxt_dev;
         le_ff    <= nxt_le;
         retry_ff <= nxt_retry;
         rtw_ff   <= nxt_rtw;
         ab_ff    <= nxt_ab;
         rd_ff    <= nxt_rd;
         rdy_ff   <= nxt_rdy;
         err_ff   <= nxt_err;
         act_ff   <= nxt_act;
         irq_ff   <= nxt_irq;
      end
   end

   assign prdata  = rd_ff;
   assign pready  = rdy_ff;
   assign pslverr = err_ff;
   assign act     = act_ff;
   assign irq     = irq_ff;

   // Checks
   a_ovf_sets: assert property (@(posedge pclk) disable iff (!presetn)
      evt.rd_overflow |=> sts_ff[SPEH_ST_OFS]) else $error("overflow not flagged");
   a_fbs_record: assert property (@(posedge pclk) disable iff (!presetn)
      (evt.rd_overflow && fbs_ff) |=> sde_ff && dev_ff == $past(evt.dev[DEV_W-1:0]))
      else $error("device not recorded");
   a_pio_fatal: assert property (@(posedge pclk) disable iff (!presetn)
      evt.pio_data_len |=> sts_ff[SPEH_ST_IFS] && le_ff[SPEH_LE_PROTO] && act_ff.send_rerr && halt_ff)
      else $error("pio mismatch not fatal");
   a_ctl_escape: assert property (@(posedge pclk) disable iff (!presetn)
      (evt.esc_h2d_ctl && fbs_ff && !evt.esc_d2h && !evt.esc_h2d_data && !evt.pio_data_odd
       && !evt.pio_data_len && !evt.rerr_h2d_data && !evt.crc_data && !evt.d2h_dma_setup)
      |=> sts_ff[SPEH_ST_INFS] && !$rose(sts_ff[SPEH_ST_IFS])) else $error("escape class");
   a_crc_data: assert property (@(posedge pclk) disable iff (!presetn)
      evt.crc_data |=> sts_ff[SPEH_ST_IFS] ##1 !cr_ff) else $error("crc data not fatal");
   a_stray_drop: assert property (@(posedge pclk) disable iff (!presetn)
      (evt.d2h_fis && !evt.slot_active) |=> !act_ff.post_fis) else $error("stray posted");
   a_halt_cr: assert property (@(posedge pclk) disable iff (!presetn)
      halt_ff |-> !cr_ff && !act_ff.ack_dma_setup) else $error("running while halted");
   a_irq_or: assert property (@(posedge pclk) disable iff (!presetn)
      irq_ff == (|(sts_ff & en_ff) && glob_ff)) else $error("irq mismatch");
   a_abort_esc: assert property (@(posedge pclk) disable iff (!presetn)
      (evt.esc_h2d_data && ab_ff == SPEH_IDLE) |=> act_ff.send_escape ##1 !act_ff.send_escape)
      else $error("no escape");
   a_retry_once: assert property (@(posedge pclk) disable iff (!presetn)
      act_ff.retry_ctl |=> !act_ff.retry_ctl) else $error("resend not single");
   a_stray_setup: assert property (@(posedge pclk) disable iff (!presetn)
      (evt.d2h_fis && evt.d2h_dma_setup && !evt.slot_active) |=> sts_ff[SPEH_ST_IFS] && halt_ff)
      else $error("stray setup not fatal");
   a_write_ovf: assert property (@(posedge pclk) disable iff (!presetn)
      evt.wr_dma_activate |=> sts_ff[SPEH_ST_OFS] && act_ff.send_hold) else $error("write overflow");
   c_overflow: cover property (@(posedge pclk) evt.rd_overflow ##1 irq_ff);
   c_wr_ovf:   cover property (@(posedge pclk) act_ff.send_hold);
   c_halt:     cover property (@(posedge pclk) $rose(halt_ff));
   c_restart:  cover property (@(posedge pclk) $fell(halt_ff) ##1 cr_ff);
   c_retry:    cover property (@(posedge pclk) act_ff.retry_ctl);
endmodule // speh_port_error

//--- tb/speh_dev_model.sv
`timescale 1ns/100ps
// Far-side device: commanded event pulses plus own replies to link actions
module speh_dev_model
   import speh_pkg::*;
(
   input  wire logic      pclk,
   input  wire logic      presetn,
   input  wire speh_act_t act,
   output speh_evt_t      evt
);
   speh_evt_t  drv;       // Events commanded by the bench
   speh_evt_t  rsp;       // Own replies
   logic [1:0] quiet_cnt; // Busy cycles left after an abort
   int         fail_left; // Retries still to refuse
   assign evt = drv | rsp;
   initial drv = '0;
   initial fail_left = 0;
   // One-cycle event, launched right after an edge
   task automatic fire(input speh_evt_t e);
      @(posedge pclk);
      drv <= e;
      @(posedge pclk);
      drv <= '0;
   endtask
   // Replies: busy after escape, error FIS, then quiet; retry outcome
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         quiet_cnt <= 2'h0;
         rsp       <= '0;
      end
      else
      begin
         rsp <= '0;
         // Busy for a few cycles after the host escapes
         if (act.send_escape)
            quiet_cnt <= 2'h3;
         else if (quiet_cnt != 2'h0)
            quiet_cnt <= quiet_cnt - 2'h1;
         rsp.link_idle <= (quiet_cnt == 2'h0) && !act.send_escape;
         // Error Register FIS in the last busy cycle, one cycle before quiet
         if (quiet_cnt == 2'h1)
         begin
            rsp.d2h_fis     <= 1'h1;
            rsp.d2h_reg_err <= 1'h1;
            rsp.slot_active <= 1'h1;
         end
         // Refuse the first retries, then accept
         if (act.retry_ctl && fail_left > 0)
         begin
            rsp.rerr_h2d_ctl <= 1'h1;
            fail_left--;
         end
         else if (act.retry_ctl)
            rsp.ctl_done <= 1'h1;
      end
   end
endmodule // speh_dev_model

//--- tb/testbench.sv
`timescale 1ns/100ps
// Self-checking bench for the port error block
module testbench
   import speh_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;   // APB address
   logic [31:0] pwdata;  // APB write data
   logic [31:0] prdata;  // APB read data
   logic [31:0] q;       // Last read word
   logic        err;     // Last pslverr taken
   logic [15:0] bc_seen; // Last descriptor byte count
   speh_evt_t   evt;     // Device events
   speh_act_t   act;     // Link actions
   int          n_fail, samples_checked, n_esc, n_rerr, n_retry, n_post, n_hold, n_ack;
   speh_port_error i_speh_port_error (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .evt(evt), .act(act), .irq(irq));
   speh_dev_model i_speh_dev_model (.pclk(pclk), .presetn(presetn), .act(act), .evt(evt));
   // Clock
   initial
   begin
      pclk = 1'h0;
      forever #10 pclk = ~pclk;
   end
   // Action monitor
   always @(posedge pclk)
   begin
      if (act.bc_we === 1'h1) bc_seen <= act.bc_value;
      if (act.send_escape === 1'h1) n_esc++;
      if (act.send_rerr === 1'h1) n_rerr++;
      if (act.retry_ctl === 1'h1) n_retry++;
      if (act.post_fis === 1'h1) n_post++;
      if (act.send_hold === 1'h1) n_hold++;
      if (act.ack_dma_setup === 1'h1) n_ack++;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One APB transfer, waits for pready under a bound
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 40);
      if (n >= 40)
      begin
         chk("pready", 32'h1, 32'h0);
         end_sim();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'h0; penable <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a); apb(1'h0, a, 32'h0); endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'h1, a, d); endtask
   task automatic fire(input speh_evt_t e); i_speh_dev_model.fire(e); endtask
   // Clear all sticky bits
   task automatic clr();
      wr(SPEH_OFF_STATUS, 32'h3F);
      wr(SPEH_OFF_LINKERR, 32'h7);
      wr(SPEH_OFF_PORTST, 32'h4);
   endtask
   task automatic t_reset();
      for (int i = 0; i < 5; i++)
      begin
         rd(8'(4 * i));
         chk("reset word", SPEH_RST_WORD, q);
         chk("pslverr", 32'h0, {31'h0, err});
      end
      rd(8'h14);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, q);
   endtask
   task automatic t_ovf();
      speh_evt_t e;
      e = '0;
      e.rd_overflow = 1'h1;
      fire(e); wt(2);
      chk("irq ovf", 32'h1, {31'h0, irq});
      rd(SPEH_OFF_STATUS); chk("ovf status", 32'h1 << SPEH_ST_OFS, q);
      rd(SPEH_OFF_PORTST); chk("still running", 32'h1, q & 32'h3);
      clr(); wt(2);
      rd(SPEH_OFF_STATUS); chk("w1c", 32'h0, q);
      chk("irq off", 32'h0, {31'h0, irq});
      wr(SPEH_OFF_ENABLE, 32'h3F);
      fire(e); wt(3);
      chk("irq global off", 32'h0, {31'h0, irq});
      clr();
      wr(SPEH_OFF_ENABLE, 32'h8000_003F);
      e = '0; e.rd_underflow = 1'h1; e.last_fis_bytes = 16'h0123;
      fire(e); wt(3);
      chk("byte count", 32'h0123, {16'h0, bc_seen});
      n_post = 0;
      e = '0; e.d2h_fis = 1'h1;
      fire(e); wt(3);
      rd(SPEH_OFF_STATUS); chk("stray status", 32'h0, q);
      rd(SPEH_OFF_LINKERR); chk("stray link", 32'h0, q);
      chk("stray post", 32'h0, n_post);
   endtask
   // Non-fatal case with switching on
   task automatic nf(input speh_evt_t e, input logic [31:0] st, input logic [31:0] m, input logic [31:0] p);
      fire(e); wt(8);
      rd(SPEH_OFF_STATUS); chk("nf status", st, q);
      rd(SPEH_OFF_PORTST); chk("nf port", p, q & m);
   endtask
   task automatic t_fbs();
      speh_evt_t e;
      wr(SPEH_OFF_CONTROL, 32'h3);
      e = '0; e.rd_overflow = 1'h1; e.dev = 4'h5;
      nf(e, 32'h1, 32'hF7, 32'h55); clr();
      e = '0; e.esc_h2d_ctl = 1'h1; e.dev = 4'h6;
      nf(e, 32'h1 << SPEH_ST_INFS, 32'hF7, 32'h65); clr();
      e = '0; e.crc_ctl = 1'h1;
      nf(e, 32'h1 << SPEH_ST_INFS, 32'h3, 32'h1); clr();
      e = '0; e.rerr_h2d_data = 1'h1; e.slot_active = 1'h1;
      nf(e, 32'h0, 32'h3, 32'h1);
      rd(SPEH_OFF_LINKERR); chk("rerr link", 32'h1 << SPEH_LE_RERR, q & 32'h4); clr();
      i_speh_dev_model.fail_left = 1;
      n_retry = 0;
      e = '0; e.rerr_h2d_ctl = 1'h1;
      nf(e, 32'h1 << SPEH_ST_INFS, 32'h3, 32'h1);
      chk("retries", 32'h2, n_retry); clr();
   endtask
   // Switching Register FIS, queued underflow, DMA setup, write overflow
   task automatic t_misc();
      speh_evt_t e;
      n_post = 0;
      e = '0; e.d2h_fis = 1'h1; e.slot_active = 1'h1; e.d2h_reg_err = 1'h1; e.dev = 4'h9;
      nf(e, 32'h0, 32'hF7, 32'h95);
      chk("reg fis posted", 32'h1, n_post);
      clr();
      e = '0; e.rd_underflow = 1'h1; e.ncq_cmd = 1'h1; e.last_fis_bytes = 16'h0456;
      fire(e); wt(3);
      chk("queued byte count", 32'h0123, {16'h0, bc_seen});
      n_ack = 0;
      e = '0; e.d2h_fis = 1'h1; e.d2h_dma_setup = 1'h1; e.slot_active = 1'h1;
      fire(e); wt(3);
      chk("setup ack", 32'h1, n_ack);
      n_hold = 0; n_esc = 0;
      e = '0; e.wr_dma_activate = 1'h1;
      nf(e, 32'h1, 32'hF7, 32'h05);
      chk("hold sent", 32'h1, n_hold);
      chk("write abort", 32'h1, n_esc);
      clr();
   endtask
   function automatic speh_evt_t mk(input int i);
      speh_evt_t e;
      e = '0;
      e.slot_active = 1'h1;
      case (i)
         0: e.pio_data_odd = 1'h1;
         1: e.pio_data_len = 1'h1;
         2: e.esc_d2h = 1'h1;
         3: e.esc_h2d_data = 1'h1;
         4: e.esc_h2d_ctl = 1'h1;
         5: e.rerr_h2d_data = 1'h1;
         6: e.crc_data = 1'h1;
         7: begin e.d2h_fis = 1'h1; e.d2h_dma_setup = 1'h1; e.slot_active = 1'h0; end
         8: e.host_bus_fatal = 1'h1;
         9: e.host_data_err = 1'h1;
         default: e.taskfile_err = 1'h1;
      endcase
      return e;
   endfunction
   // Every fatal cause: halt, then restart by start 0 then 1
   task automatic t_fatal();
      int b;
      wr(SPEH_OFF_CONTROL, 32'h0); wr(SPEH_OFF_CONTROL, 32'h1);
      for (int i = 0; i < 11; i++)
      begin
         b = (i < 8) ? SPEH_ST_IFS : SPEH_ST_HBFS + i - 8;
         n_esc = 0; n_rerr = 0;
         fire(mk(i)); wt(2);
         chk("irq early", 32'h1, {31'h0, irq});
         wt(6);
         rd(SPEH_OFF_STATUS); chk("fatal bit", 32'h1, (q >> b) & 32'h1);
         rd(SPEH_OFF_PORTST); chk("halted", 32'h2, q & 32'h3);
         chk("no issue", 32'h0, {31'h0, act.issue_ok});
         if (i < 2) rd(SPEH_OFF_LINKERR);
         if (i < 2) chk("proto", 32'h1, q & 32'h1);
         if (i == 1) chk("rerr sent", 32'h1, {31'h0, n_rerr > 0});
         if (i == 3) chk("escape sent", 32'h1, n_esc);
         wr(SPEH_OFF_CONTROL, 32'h1); wr(SPEH_OFF_PORTST, 32'h0);
         rd(SPEH_OFF_PORTST); chk("no restart", 32'h2, q & 32'h3);
         wr(SPEH_OFF_CONTROL, 32'h0); wr(SPEH_OFF_CONTROL, 32'h1); clr();
         rd(SPEH_OFF_PORTST); chk("restarted", 32'h1, q & 32'h3);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #400000;
      n_fail++;
      end_sim();
   end
   // Main sequence
   initial
   begin
      presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h0; pwdata = 32'h0;
      n_fail = 0; samples_checked = 0; n_esc = 0; n_rerr = 0; n_retry = 0; n_post = 0;
      wt(4);
      presetn <= 1'h1;
      t_reset();
      wr(SPEH_OFF_ENABLE, 32'h8000_003F);
      wr(SPEH_OFF_CONTROL, 32'h1);
      rd(SPEH_OFF_PORTST); chk("running", 32'h1, q & 32'h3);
      t_ovf();
      t_fbs();
      t_misc();
      t_fatal();
      end_sim();
   end
endmodule // testbench
